/* verilog/flash_guard_defs.svh */
// register map, field positions, reset values and timing counts
`ifndef FLASH_GUARD_DEFS_SVH
`define FLASH_GUARD_DEFS_SVH

`define OFS_CTRL 12'h000
`define OFS_ADDR 12'h004
`define OFS_WDATA 12'h008
`define OFS_STATUS 12'h00C
`define OFS_RDATA 12'h010

`define CTRL_GO 0
`define CTRL_OP_LO 1
`define CTRL_OP_HI 2
`define CTRL_WP 4
`define CTRL_RST 5

`define STAT_BUSY 0
`define STAT_DONE 1
`define STAT_TMO 2
`define STAT_RDY 3
`define STAT_REFUSED 4

`define CTRL_WP_RESET 1'b1
`define CTRL_RST_RESET 1'b0
`define TOGGLE_BIT 6

`define CLK_PERIOD_NS 8
`define T_SETUP_NS 10
`define T_WE_LOW_NS 35
`define T_HOLD_NS 20
`define T_ACCESS_NS 80
`define T_GAP_NS 20
`define SYNC_STAGES 2
`define CYC_SETUP ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_WE ((`T_WE_LOW_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_HOLD ((`T_HOLD_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define CYC_ACCESS \
    ((`T_ACCESS_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS + `SYNC_STAGES)
`define CYC_GAP ((`T_GAP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define POLL_LIMIT_DEFAULT 16'h4E20

`endif

/* verilog/flash_guard_pkg.sv */
// types shared by the flash protection host controller
package flash_guard_pkg;
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_W_SETUP,
        ST_W_LOW,
        ST_W_HOLD,
        ST_R_ACCESS,
        ST_R_GAP
    } state_t;

    typedef enum logic [1:0] {
        OP_WRITE,
        OP_READ,
        OP_POLL,
        OP_SPARE
    } op_t;
endpackage : flash_guard_pkg

/* verilog/pin_sync.sv */
// two-flop synchroniser for pin inputs
`timescale 1ns/100ps
module pin_sync #(
    parameter int W = 17
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // pins in, synchronised out
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    typedef struct packed {
        logic [W-1:0] s1;
        logic [W-1:0] s2;
    } sync_t;

    sync_t s_q;
    sync_t s_d;

    always_comb begin
        s_d.s1 = d;
        s_d.s2 = s_q.s1;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign q = s_q.s2;
endmodule : pin_sync

/* verilog/flash_guard_host.sv */
// host controller issuing command cycles to a protected parallel flash
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/100ps
`include "flash_guard_defs.svh"

// Behaviour
// - host issues exit only after the operation completes
// - host tracks completion by toggle bit and ready/busy only
// - host sets freeze only after all guard bits configured; the host does not check this, it passes each command as a plain write
// - host keeps write-protect level stable during any sequence
module flash_guard_host
    import flash_guard_pkg::*;
#(
    parameter logic [15:0] POLL_LIMIT = `POLL_LIMIT_DEFAULT
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // apb slave
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // flash pins
    output logic [21:0] flash_addr,
    output logic [15:0] dq_out,
    output logic dq_oe,
    input wire logic [15:0] dq_in,
    output logic ce_n,
    output logic we_n,
    output logic oe_n,
    output logic flash_reset_n,
    output logic write_protect_accel_pin,
    input wire logic ready_busy_out
);
    typedef struct packed {
        state_t st;
        logic [3:0] cnt;
        op_t op;
        logic [21:0] addr;
        logic [15:0] wdata;
        logic [15:0] rdata;
        logic [15:0] prev;
        logic have_prev;
        logic [15:0] polls;
        logic ctrl_wp;
        logic ctrl_rst;
        logic wp_pin;
        logic rst_pin_n;
        logic done;
        logic tmo;
        logic refused;
        logic ce_n;
        logic we_n;
        logic oe_n;
        logic dq_oe;
        logic pready;
        logic [31:0] prdata;
        logic pslverr;
    } host_t;

    host_t s_q;
    host_t s_d;
    logic [15:0] dq_s;
    logic rdy_s;
    logic wr_acc;
    logic go_req;
    logic start_rd;

    pin_sync #(.W(17)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .d({ready_busy_out, dq_in}),
        .q({rdy_s, dq_s})
    );

    assign wr_acc = psel && penable && s_q.pready && pwrite;
    assign go_req = wr_acc && (paddr == `OFS_CTRL) && pwdata[`CTRL_GO];

    always_comb begin
        s_d = s_q;
        start_rd = 1'b0;
        // apb answers one cycle after setup
        s_d.pready = psel && !penable;
        s_d.pslverr = 1'b0;
        if (psel && !penable) begin
            unique case (paddr)
                `OFS_CTRL: begin
                    s_d.prdata = 32'h0000_0000;
                    s_d.prdata[`CTRL_OP_HI:`CTRL_OP_LO] = s_q.op;
                    s_d.prdata[`CTRL_WP] = s_q.ctrl_wp;
                    s_d.prdata[`CTRL_RST] = s_q.ctrl_rst;
                end
                `OFS_ADDR: s_d.prdata = {10'h000, s_q.addr};
                `OFS_WDATA: s_d.prdata = {16'h0000, s_q.wdata};
                `OFS_STATUS: begin
                    s_d.prdata = 32'h0000_0000;
                    s_d.prdata[`STAT_BUSY] = s_q.st != ST_IDLE;
                    s_d.prdata[`STAT_DONE] = s_q.done;
                    s_d.prdata[`STAT_TMO] = s_q.tmo;
                    s_d.prdata[`STAT_RDY] = rdy_s;
                    s_d.prdata[`STAT_REFUSED] = s_q.refused;
                end
                `OFS_RDATA: s_d.prdata = {16'h0000, s_q.rdata};
                default: begin
                    s_d.prdata = 32'h0000_0000;
                    s_d.pslverr = 1'b1;
                end
            endcase
        end
        if (wr_acc) begin
            unique case (paddr)
                `OFS_CTRL: begin
                    s_d.ctrl_wp = pwdata[`CTRL_WP];
                    s_d.ctrl_rst = pwdata[`CTRL_RST];
                end
                `OFS_ADDR: s_d.addr = pwdata[21:0];
                `OFS_WDATA: s_d.wdata = pwdata[15:0];
                `OFS_STATUS: begin
                    if (pwdata[`STAT_REFUSED]) begin
                        s_d.refused = 1'b0;
                    end
                end
                default: begin
                end
            endcase
        end
        // pin levels follow control bits only between sequences
        if (s_q.st == ST_IDLE && !go_req) begin
            s_d.wp_pin = s_q.ctrl_wp;
            s_d.rst_pin_n = !s_q.ctrl_rst;
        end
        // a new request while one runs is refused, so exit waits
        if (go_req && s_q.st != ST_IDLE) begin
            s_d.refused = 1'b1;
        end
        unique case (s_q.st)
            ST_IDLE: begin
                if (go_req) begin
                    // each cycle is a plain write, so software keeps the
                    // freeze command after all guard bits are set
                    s_d.op = op_t'(pwdata[`CTRL_OP_HI:`CTRL_OP_LO]);
                    s_d.done = 1'b0;
                    s_d.tmo = 1'b0;
                    s_d.have_prev = 1'b0;
                    s_d.polls = 16'h0000;
                    s_d.ce_n = 1'b0;
                    if (op_t'(pwdata[`CTRL_OP_HI:`CTRL_OP_LO]) == OP_WRITE)
                    begin
                        s_d.dq_oe = 1'b1;
                        s_d.st = ST_W_SETUP;
                        s_d.cnt = 4'(`CYC_SETUP - 1);
                    end else begin
                        start_rd = 1'b1;
                    end
                end
            end
            ST_W_SETUP: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (s_q.cnt == 4'h0) begin
                    s_d.we_n = 1'b0;
                    s_d.st = ST_W_LOW;
                    s_d.cnt = 4'(`CYC_WE - 1);
                end
            end
            ST_W_LOW: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (s_q.cnt == 4'h0) begin
                    s_d.we_n = 1'b1;
                    s_d.st = ST_W_HOLD;
                    s_d.cnt = 4'(`CYC_HOLD - 1);
                end
            end
            ST_W_HOLD: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (s_q.cnt == 4'h0) begin
                    s_d.ce_n = 1'b1;
                    s_d.dq_oe = 1'b0;
                    s_d.st = ST_IDLE;
                    s_d.done = 1'b1;
                end
            end
            ST_R_ACCESS: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (s_q.cnt == 4'h0) begin
                    s_d.rdata = dq_s;
                    s_d.oe_n = 1'b1;
                    s_d.ce_n = 1'b1;
                    s_d.st = ST_R_GAP;
                    s_d.cnt = 4'(`CYC_GAP - 1);
                end
            end
            ST_R_GAP: begin
                s_d.cnt = s_q.cnt - 4'h1;
                if (s_q.cnt == 4'h0) begin
                    if (s_q.op != OP_POLL) begin
                        s_d.st = ST_IDLE;
                        s_d.done = 1'b1;
                    end else if (s_q.have_prev && rdy_s &&
                        s_q.rdata[`TOGGLE_BIT] == s_q.prev[`TOGGLE_BIT])
                    begin
                        // toggle stopped and ready high: finished
                        s_d.st = ST_IDLE;
                        s_d.done = 1'b1;
                    end else if (s_q.polls == POLL_LIMIT) begin
                        s_d.st = ST_IDLE;
                        s_d.done = 1'b1;
                        s_d.tmo = 1'b1;
                    end else begin
                        s_d.prev = s_q.rdata;
                        s_d.have_prev = 1'b1;
                        s_d.polls = s_q.polls + 16'h0001;
                        s_d.ce_n = 1'b0;
                        start_rd = 1'b1;
                    end
                end
            end
            default: begin
                s_d.st = ST_IDLE;
            end
        endcase
        if (start_rd) begin
            s_d.oe_n = 1'b0;
            s_d.st = ST_R_ACCESS;
            s_d.cnt = 4'(`CYC_ACCESS - 1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.st <= ST_IDLE;
            s_q.op <= OP_WRITE;
            s_q.ctrl_wp <= `CTRL_WP_RESET;
            s_q.ctrl_rst <= `CTRL_RST_RESET;
            s_q.wp_pin <= `CTRL_WP_RESET;
            s_q.rst_pin_n <= 1'b1;
            s_q.ce_n <= 1'b1;
            s_q.we_n <= 1'b1;
            s_q.oe_n <= 1'b1;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign flash_addr = s_q.addr;
    assign dq_out = s_q.wdata;
    assign dq_oe = s_q.dq_oe;
    assign ce_n = s_q.ce_n;
    assign we_n = s_q.we_n;
    assign oe_n = s_q.oe_n;
    assign flash_reset_n = s_q.rst_pin_n;
    assign write_protect_accel_pin = s_q.wp_pin;

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    busy_refuse_a: assert property (
        (go_req && s_q.st != ST_IDLE) |=>
        s_q.refused && s_q.op == $past(s_q.op))
        else $error("request during a running sequence not refused");

    poll_finish_a: assert property (
        (s_q.st == ST_R_GAP && s_q.cnt == 4'h0 && s_q.op == OP_POLL &&
         s_q.have_prev && rdy_s &&
         s_q.rdata[`TOGGLE_BIT] == s_q.prev[`TOGGLE_BIT])
        |=> s_q.done && !s_q.tmo && s_q.st == ST_IDLE)
        else $error("poll did not finish on settled toggle bit");

    poll_busy_a: assert property (
        (s_q.st == ST_R_GAP && s_q.cnt == 4'h0 && s_q.op == OP_POLL &&
         !rdy_s && s_q.polls != POLL_LIMIT)
        |=> !s_q.done ##1 s_q.st == ST_R_ACCESS)
        else $error("poll ended while device busy");

    wp_stable_a: assert property (
        (s_q.st != ST_IDLE) |-> $stable(write_protect_accel_pin))
        else $error("write-protect level changed inside a sequence");

    rst_stable_a: assert property (
        (!ce_n) |-> $stable(flash_reset_n))
        else $error("reset pin changed during a cycle");

    we_width_a: assert property (
        $fell(we_n) |-> !we_n [*5] ##1 we_n)
        else $error("write pulse width wrong");

    no_clash_a: assert property (
        !oe_n |-> !dq_oe && we_n)
        else $error("bus driven while flash outputs enabled");

    apb_answer_a: assert property (
        (psel && !penable) |=> pready ##1 !pready)
        else $error("apb answer not in first access cycle");

    write_seen_c: cover property ($rose(we_n) && !ce_n);
    poll_done_c: cover property (s_q.op == OP_POLL && $rose(s_q.done));
    poll_tmo_c: cover property ($rose(s_q.tmo));
    refuse_c: cover property ($rose(s_q.refused));
endmodule : flash_guard_host

/* tb/flash_guard_model.sv */
// behavioural parallel flash with sector guard bits, host's far side
`timescale 1ns/100ps
module flash_guard_model #(
    parameter logic VOL_DEFAULT = 1'b1,
    parameter int BUSY_NS = 300,
    // command codes are arbitrary, carried in the upper data byte
    parameter logic [7:0] CMD_ENTER = 8'hC0,
    parameter logic [7:0] CMD_EXIT = 8'h90,
    parameter logic [7:0] CMD_FREEZE = 8'h50,
    parameter logic [7:0] CMD_VSET = 8'hB0,
    parameter logic [7:0] CMD_VCLR = 8'hB1,
    parameter logic [7:0] CMD_PPROG = 8'hA0,
    parameter logic [7:0] CMD_PERASE = 8'hA1
) (
    // flash pins
    input wire logic [21:0] flash_addr,
    input wire logic [15:0] dq_out,
    input wire logic dq_oe,
    output logic [15:0] dq_in,
    input wire logic ce_n,
    input wire logic we_n,
    input wire logic oe_n,
    input wire logic flash_reset_n,
    input wire logic write_protect_accel_pin,
    output logic ready_busy_out
);
    logic [15:0] mem [8];
    logic [1:0] pers;
    logic [7:0] vol;
    logic freeze, guard_mode, busy, tog, er, g;
    // supply below the lockout threshold; the bench keeps it good
    logic lockout;
    realtime t_fall;
    logic [15:0] rdv, last;
    logic [2:0] s;
    assign s = flash_addr[2:0];
    assign ready_busy_out = !busy;
    function automatic logic prot(input logic [2:0] i);
        // a floating pin reads high through the pull-up
        return !pers[i[2]] || !vol[i] ||
            (i == 3'd0 &&
             write_protect_accel_pin === 1'b0);
    endfunction : prot
    initial begin
        foreach (mem[i]) mem[i] = 16'hFFFF;
        pers = 2'b11;
        busy = 1'b0;
        tog = 1'b0;
        last = 16'h0000;
        freeze = 1'b1;
        vol = {8{VOL_DEFAULT}};
        guard_mode = 1'b0;
        lockout = 1'b0;
        t_fall = 0.0;
    end
    always @(negedge flash_reset_n) begin
        freeze = 1'b1;
        vol = {8{VOL_DEFAULT}};
        guard_mode = 1'b0;
    end
    always @(posedge lockout) guard_mode = 1'b0;
    always @(negedge we_n) t_fall = $realtime;
    always @(posedge we_n) begin
        if (!ce_n && !busy && flash_reset_n && !lockout &&
            $realtime - t_fall >= 5.0) begin
            case (dq_out[15:8])
                CMD_ENTER: guard_mode = 1'b1;
                CMD_EXIT: guard_mode = 1'b0;
                CMD_FREEZE: freeze = 1'b0;
                CMD_VSET: vol[s] = 1'b0;
                CMD_VCLR: vol[s] = 1'b1;
                CMD_PPROG, CMD_PERASE: if (guard_mode) begin
                    er = dq_out[8];
                    g = s[2];
                    busy = 1'b1;
                    #(freeze ? BUSY_NS : 4 * BUSY_NS);
                    if (freeze && er) pers = 2'b11;
                    else if (freeze) pers[g] = 1'b0;
                    busy = 1'b0;
                end
                default: if (!guard_mode && !prot(s)) begin
                    mem[s] = dq_out;
                end
            endcase
        end
    end
    always @(negedge oe_n) begin
        if (busy) tog = !tog;
    end
    assign rdv = busy ? {9'h000, tog, 6'h00} :
        guard_mode ? {15'h0000, pers[s[2]]} : mem[s];
    // a released bus shows the inverse of the last word, never a held value
    assign dq_in = (!ce_n && !oe_n) ? rdv : ~last;
    always @(posedge oe_n) last = rdv;
endmodule : flash_guard_model

/* tb/flash_guard_host_tb.sv */
// self-checking bench for the flash protection host controller
`timescale 1ns/100ps
`include "flash_guard_defs.svh"
module flash_guard_host_tb import flash_guard_pkg::*;;
    logic clk, rst_n, psel, penable, pwrite, pready, pslverr, err_v;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic [21:0] flash_addr;
    logic [15:0] dq_out, dq_in;
    logic dq_oe, ce_n, we_n, oe_n, flash_reset_n, wp_pin, rb, wp_v;
    int n_errors = 0;
    int total_checks = 0;
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    flash_guard_host #(.POLL_LIMIT(16'h0004)) dut (
        .clk(clk), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .flash_reset_n(flash_reset_n), .write_protect_accel_pin(wp_pin),
        .ready_busy_out(rb));
    flash_guard_model flash (
        .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe),
        .dq_in(dq_in), .ce_n(ce_n), .we_n(we_n), .oe_n(oe_n),
        .flash_reset_n(flash_reset_n), .write_protect_accel_pin(wp_pin),
        .ready_busy_out(rb));
    task automatic stop_test;
        $display("checks %0d mismatches %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : stop_test
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic apb(input logic w, input logic [11:0] a,
            input logic [31:0] d, output logic [31:0] r);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) begin
            n_errors++;
            stop_test();
        end
        r = prdata;
        err_v = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d, rv);
    endtask : wr
    task automatic rd(input logic [11:0] a, output logic [31:0] r);
        apb(1'b0, a, 32'h0000_0000, r);
    endtask : rd
    // poll the status register until the running operation is done
    task automatic wait_done;
        int k;
        k = 0;
        do begin
            rd(`OFS_STATUS, rv);
            k++;
        end while (rv[`STAT_DONE] !== 1'b1 && k < 100);
        if (k >= 100) begin
            n_errors++;
            stop_test();
        end
    endtask : wait_done
    // one flash operation, waited for through the status register
    task automatic op(input logic [1:0] o, input logic [21:0] a,
            input logic [15:0] d);
        wr(`OFS_ADDR, {10'h000, a});
        wr(`OFS_WDATA, {16'h0000, d});
        wr(`OFS_CTRL, {26'h000_0000, 1'b0, wp_v, 1'b0, o, 1'b1});
        wait_done();
    endtask : op
    task automatic cmd(input logic [7:0] c, input logic [21:0] a);
        op(2'd0, a, {c, 8'h00});
    endtask : cmd
    task automatic exp_rd(input logic [21:0] a, input logic [15:0] d);
        op(2'd1, a, 16'h0000);
        rd(`OFS_RDATA, rv);
        check(rv, {16'h0000, d});
    endtask : exp_rd
    task automatic exp_poll(input logic [31:0] t);
        op(2'd2, 22'h00_0000, 16'h0000);
        check(rv & 32'h0000_0004, t);
    endtask : exp_poll
    initial begin
        rst_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0000_0000;
        wp_v = 1'b1;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(`OFS_CTRL, rv);
        check(rv, 32'h0000_0010);
        check({31'h0000_0000, wp_pin}, 32'h0000_0001);
        rd(12'h020, rv);
        check({31'h0000_0000, err_v}, 32'h0000_0001);
        $display("test reset done");
        fw_block: begin
            op(2'd0, 22'd1, 16'h1234);
            exp_rd(22'd1, 16'h1234);
            cmd(flash.CMD_VSET, 22'd2);
            op(2'd0, 22'd2, 16'h5555);
            exp_rd(22'd2, 16'hFFFF);
            cmd(flash.CMD_VCLR, 22'd2);
            op(2'd0, 22'd2, 16'h5555);
            exp_rd(22'd2, 16'h5555);
        end
        $display("test volatile done");
        wr(`OFS_ADDR, 32'h0000_0001);
        wr(`OFS_CTRL, 32'h0000_0013);
        wr(`OFS_CTRL, 32'h0000_0013);
        rd(`OFS_STATUS, rv);
        check(rv, 32'h0000_0019);
        wait_done();
        check(rv, 32'h0000_001A);
        wr(`OFS_STATUS, 32'h0000_0010);
        rd(`OFS_STATUS, rv);
        check(rv, 32'h0000_000A);
        rd(`OFS_RDATA, rv);
        check(rv, 32'h0000_1234);
        $display("test refuse done");
        cmd(flash.CMD_ENTER, 22'd0);
        exp_rd(22'd1, 16'h0001);
        op(2'd0, 22'd6, 16'h6666);
        cmd(flash.CMD_PPROG, 22'd1);
        exp_poll(32'h0000_0000);
        exp_rd(22'd3, 16'h0000);
        exp_rd(22'd5, 16'h0001);
        cmd(flash.CMD_EXIT, 22'd0);
        exp_rd(22'd6, 16'hFFFF);
        op(2'd0, 22'd3, 16'h3333);
        exp_rd(22'd3, 16'hFFFF);
        op(2'd0, 22'd5, 16'h7777);
        exp_rd(22'd5, 16'h7777);
        cmd(flash.CMD_ENTER, 22'd0);
        cmd(flash.CMD_PERASE, 22'd0);
        exp_poll(32'h0000_0000);
        exp_rd(22'd3, 16'h0001);
        $display("test persistent done");
        cmd(flash.CMD_FREEZE, 22'd0);
        cmd(flash.CMD_PPROG, 22'd5);
        exp_poll(32'h0000_0004);
        op(2'd2, 22'd0, 16'h0000);
        exp_poll(32'h0000_0000);
        exp_rd(22'd5, 16'h0001);
        cmd(flash.CMD_EXIT, 22'd0);
        cmd(flash.CMD_VSET, 22'd6);
        wr(`OFS_CTRL, 32'h0000_0030);
        wr(`OFS_CTRL, 32'h0000_0010);
        op(2'd0, 22'd6, 16'h6060);
        exp_rd(22'd6, 16'h6060);
        cmd(flash.CMD_ENTER, 22'd0);
        cmd(flash.CMD_PPROG, 22'd5);
        exp_poll(32'h0000_0000);
        exp_rd(22'd5, 16'h0000);
        cmd(flash.CMD_EXIT, 22'd0);
        $display("test freeze done");
        wp_v = 1'b0;
        wr(`OFS_CTRL, 32'h0000_0000);
        @(posedge clk);
        check({31'h0000_0000, wp_pin}, 32'h0000_0000);
        op(2'd0, 22'd0, 16'h0A0A);
        exp_rd(22'd0, 16'hFFFF);
        wp_v = 1'b1;
        wr(`OFS_CTRL, 32'h0000_0010);
        op(2'd0, 22'd0, 16'h0A0A);
        exp_rd(22'd0, 16'h0A0A);
        $display("test write protect done");
        stop_test();
    end
endmodule : flash_guard_host_tb
